// ===== design/isar_pkg.sv
// Constants and types for the two-wire slave address receiver
package isar_pkg;
	// Mode field codes
	localparam logic [3:0] MODE_MST = 4'h8;
	localparam logic [3:0] MODE_S7 = 4'h6;
	localparam logic [3:0] MODE_S10 = 4'h7;
	localparam logic [3:0] MODE_FWM = 4'hB;
	localparam logic [3:0] MODE_S7SS = 4'hE;
	localparam logic [3:0] MODE_S10SS = 4'hF;
	// Bit counter marks within one byte frame
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_DONE = 4'h9;
	// Ten-bit header, address compare helpers and reset values
	localparam logic [4:0] TENBIT_HDR = 5'h1E;
	localparam logic [7:0] RW_BIT_MASK = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] TX_IDLE = 8'hFF;

	typedef struct packed {
		logic address_update_flag;
		logic receive_overflow_flag;
		logic buffer_full_flag;
		logic port_interrupt_flag;
	} isar_flags_t;

	typedef struct packed {
		logic scl_lvl;
		logic sda_lvl;
		logic scl_rise;
		logic scl_fall;
		logic sda_rise;
		logic sda_fall;
	} isar_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR2 = 3'b010,
		ST_RX = 3'b011,
		ST_TX = 3'b100
	} isar_state_t;
endpackage

// ===== design/isar_sync.sv
// Pin synchroniser and edge finder for the serial clock and data pins
`timescale 1ns/1ps
module isar_sync
	import isar_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl_i,
	input wire logic sda_i,
	output isar_pins_t pins
);
	logic [1:0] s1_q;
	logic [1:0] s2_q;
	logic [1:0] s3_q;

	// Idle bus is high, so reset to high to avoid a false start
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			s3_q <= 2'h3;
		end else begin
			s1_q <= {scl_i, sda_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_comb begin
		pins.scl_lvl = s2_q[1];
		pins.sda_lvl = s2_q[0];
		pins.scl_rise = s2_q[1] & ~s3_q[1];
		pins.scl_fall = ~s2_q[1] & s3_q[1];
		pins.sda_rise = s2_q[0] & ~s3_q[0];
		pins.sda_fall = ~s2_q[0] & s3_q[0];
	end
endmodule

// ===== design/isar_slave.sv
// Two-wire slave: address match, auto acknowledge, receive buffer, flags
`timescale 1ns/1ps
module isar_slave
	import isar_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic port_enable_bit,
	input wire logic [3:0] port_mode,
	input wire logic pins_are_inputs,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe,
	output logic sda_o,
	output logic sda_oe,
	input wire logic addr_wr,
	input wire logic [7:0] addr_wdata,
	input wire logic [7:0] addr_mask,
	input wire logic buf_rd,
	input wire logic ovf_clr,
	input wire logic pif_clr,
	input wire logic [7:0] tx_data,
	output logic [7:0] receive_buffer,
	output logic [7:0] slave_address_reg,
	output logic [7:0] input_shift_register,
	output isar_flags_t flags,
	output logic tx_active
);
	isar_pins_t pins;
	isar_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] tx_q;
	logic hit_q;
	logic ack_q;
	logic mack_q;
	logic hi_ok_q;
	logic hit_d;
	logic ok;
	logic en_od;
	logic en_slv;
	logic start_det;
	logic stop_det;
	logic rise;
	logic fall8;
	logic fall9;
	logic ten;
	logic ua_set;
	logic tx_load;

	function automatic logic is_ten(input logic [3:0] m);
		return m == MODE_S10 || m == MODE_S10SS;
	endfunction

	function automatic logic is_ss(input logic [3:0] m);
		return m == MODE_S7SS || m == MODE_S10SS;
	endfunction

	function automatic logic is_slave(input logic [3:0] m);
		return m == MODE_S7 || is_ten(m) || is_ss(m);
	endfunction

	// Mask bit set means that address bit is a don't care
	function automatic logic am(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] m);
		return ((a ^ b) & ~m) == BYTE_ZERO;
	endfunction

	isar_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.pins(pins)
	);

	// Pins only switch to open-drain when software left them as inputs
	assign en_od = port_enable_bit & pins_are_inputs &
		(is_slave(port_mode) || port_mode == MODE_MST ||
		port_mode == MODE_FWM);
	assign en_slv = en_od & is_slave(port_mode);
	assign ten = is_ten(port_mode);
	assign start_det = en_slv & pins.scl_lvl & pins.sda_fall;
	assign stop_det = en_slv & pins.scl_lvl & pins.sda_rise;
	assign rise = en_slv & pins.scl_rise & state_q != ST_IDLE;
	assign fall8 = en_slv & pins.scl_fall & state_q != ST_IDLE &
		cnt_q == CNT_ACK;
	assign fall9 = en_slv & pins.scl_fall & state_q != ST_IDLE &
		cnt_q == CNT_DONE;
	assign ok = !flags.buffer_full_flag &&
		!flags.receive_overflow_flag;
	assign ua_set = fall9 & ack_q & ((state_q == ST_ADDR & ten &
		!input_shift_register[0]) | state_q == ST_ADDR2);
	assign tx_load = fall9 & ((state_q == ST_ADDR & ack_q &
		input_shift_register[0]) | (state_q == ST_TX & mack_q));

	// Address decision taken on the eighth falling clock edge
	always_comb begin
		hit_d = 1'b0;
		unique case (state_q)
			ST_ADDR: begin
				if (ten) begin
					hit_d = input_shift_register[7:3] == TENBIT_HDR &&
						am(input_shift_register, slave_address_reg,
						addr_mask | RW_BIT_MASK) &&
						(!input_shift_register[0] || hi_ok_q);
				end else begin
					hit_d = am(input_shift_register, slave_address_reg,
						addr_mask | RW_BIT_MASK);
				end
			end
			ST_ADDR2: begin
				hit_d = am(input_shift_register, slave_address_reg,
					addr_mask);
			end
			ST_RX: begin
				hit_d = 1'b1;
			end
			ST_IDLE, ST_TX: begin
				hit_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_ZERO;
		end else if (!en_slv) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_ZERO;
		end else if (start_det) begin
			state_q <= ST_ADDR;
			cnt_q <= CNT_ZERO;
		end else if (stop_det) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_ZERO;
		end else if (rise && cnt_q < CNT_DONE) begin
			cnt_q <= cnt_q + CNT_ONE;
		end else if (fall9) begin
			cnt_q <= CNT_ZERO;
			unique case (state_q)
				ST_ADDR: begin
					if (!ack_q) begin
						state_q <= ST_IDLE;
					end else if (input_shift_register[0]) begin
						state_q <= ST_TX;
					end else if (ten) begin
						state_q <= ST_ADDR2;
					end else begin
						state_q <= ST_RX;
					end
				end
				ST_ADDR2: begin
					state_q <= ack_q ? ST_RX : ST_IDLE;
				end
				ST_RX: begin
					state_q <= ST_RX;
				end
				ST_TX: begin
					state_q <= mack_q ? ST_TX : ST_IDLE;
				end
				ST_IDLE: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			input_shift_register <= BYTE_ZERO;
		end else if (rise && cnt_q < CNT_ACK) begin
			input_shift_register <= {input_shift_register[6:0],
				pins.sda_lvl};
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hit_q <= 1'b0;
			ack_q <= 1'b0;
		end else if (start_det || stop_det || fall9 || !en_slv) begin
			hit_q <= 1'b0;
			ack_q <= 1'b0;
		end else if (fall8) begin
			hit_q <= hit_d;
			ack_q <= hit_d & ok;
		end
	end

	// Remembers a matched high byte so a restarted read can be answered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hi_ok_q <= 1'b0;
		end else if (stop_det || !en_slv) begin
			hi_ok_q <= 1'b0;
		end else if (fall9 && state_q == ST_ADDR && ten &&
			!input_shift_register[0]) begin
			hi_ok_q <= ack_q;
		end else if (fall9 && state_q == ST_ADDR2 && !ack_q) begin
			hi_ok_q <= 1'b0;
		end
	end

	// Hardware sets win over same-cycle software clears
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags <= '0;
		end else begin
			if (pif_clr) begin
				flags.port_interrupt_flag <= 1'b0;
			end
			if (buf_rd) begin
				flags.buffer_full_flag <= 1'b0;
			end
			if (ovf_clr) begin
				flags.receive_overflow_flag <= 1'b0;
			end
			if (addr_wr) begin
				flags.address_update_flag <= 1'b0;
			end
			if ((start_det || stop_det) && is_ss(port_mode)) begin
				flags.port_interrupt_flag <= 1'b1;
			end
			if (fall9 && (hit_q || state_q == ST_TX)) begin
				flags.port_interrupt_flag <= 1'b1;
			end
			if (fall9 && ack_q && state_q != ST_TX) begin
				flags.buffer_full_flag <= 1'b1;
			end
			if (fall9 && hit_q && !ack_q) begin
				flags.receive_overflow_flag <= 1'b1;
			end
			if (ua_set) begin
				flags.address_update_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			receive_buffer <= BYTE_ZERO;
		end else if (fall9 && ack_q && state_q != ST_TX) begin
			receive_buffer <= input_shift_register;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slave_address_reg <= ADDR_RST;
		end else if (addr_wr) begin
			slave_address_reg <= addr_wdata;
		end
	end

	// Transmit byte; ones shifted in keep the line released
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_q <= TX_IDLE;
			mack_q <= 1'b0;
		end else if (tx_load) begin
			tx_q <= tx_data;
		end else if (state_q == ST_TX && en_slv) begin
			if (pins.scl_fall && cnt_q < CNT_ACK) begin
				tx_q <= {tx_q[6:0], 1'b1};
			end
			if (pins.scl_rise && cnt_q == CNT_ACK) begin
				mack_q <= !pins.sda_lvl;
			end
		end
	end

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	// Clock stays low until software rewrites the address
	assign scl_oe = en_od & flags.address_update_flag;
	// Last bit stays driven through its high time: letting go at the
	// eighth rise would show the master a stop condition
	assign sda_oe = en_od & (ack_q | (state_q == ST_TX &&
		(cnt_q < CNT_ACK || (cnt_q == CNT_ACK && pins.scl_lvl)) &&
		!tx_q[7]));
	assign tx_active = state_q == ST_TX;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_shift;
		rise && cnt_q < CNT_ACK |=> input_shift_register ==
			{$past(input_shift_register[6:0]), $past(pins.sda_lvl)};
	endproperty
	a_shift: assert property (p_shift) else $error("bad shift");

	property p_nack_full;
		fall8 && !ok |=> !ack_q ##1 !sda_oe || tx_active;
	endproperty
	a_nack_full: assert property (p_nack_full) else $error("bad ack");

	property p_load;
		fall9 && ack_q && state_q != ST_TX |=> receive_buffer ==
			$past(input_shift_register) && flags.buffer_full_flag &&
			flags.port_interrupt_flag;
	endproperty
	a_load: assert property (p_load) else $error("no load on match");

	property p_keep;
		fall9 && hit_q && !ack_q |=> $stable(receive_buffer) &&
			flags.port_interrupt_flag && flags.receive_overflow_flag;
	endproperty
	a_keep: assert property (p_keep) else $error("withheld load");

	property p_bf_rd;
		buf_rd && !fall9 |=> !flags.buffer_full_flag;
	endproperty
	a_bf_rd: assert property (p_bf_rd) else $error("full not cleared");

	property p_ov_hold;
		flags.receive_overflow_flag && !ovf_clr |=>
			flags.receive_overflow_flag;
	endproperty
	a_ov_hold: assert property (p_ov_hold) else $error("overflow lost");

	property p_ua_hold;
		fall9 && ack_q && state_q == ST_ADDR2 |=> flags.address_update_flag
			&& scl_oe;
	endproperty
	a_ua_hold: assert property (p_ua_hold) else $error("no clock hold");

	property p_ua_rel;
		flags.address_update_flag && addr_wr && !fall9 |=>
			!flags.address_update_flag && !scl_oe;
	endproperty
	a_ua_rel: assert property (p_ua_rel) else $error("no release");

	property p_od;
		(sda_oe || scl_oe) |-> en_od && !sda_o && !scl_o;
	endproperty
	a_od: assert property (p_od) else $error("drive while off");

	property p_ack_end;
		fall9 && state_q == ST_RX |=> !sda_oe;
	endproperty
	a_ack_end: assert property (p_ack_end) else $error("ack too long");

	property p_tx_first;
		tx_load && state_q == ST_ADDR |=> sda_oe == !$past(tx_data[7]);
	endproperty
	a_tx_first: assert property (p_tx_first) else $error("bad tx bit");

	property p_ss;
		start_det && is_ss(port_mode) |=> flags.port_interrupt_flag;
	endproperty
	a_ss: assert property (p_ss) else $error("no start flag");

	property p_ten_rd;
		fall9 && ack_q && state_q == ST_ADDR && ten &&
			input_shift_register[0] |=> tx_active &&
			flags.buffer_full_flag && !$rose(flags.address_update_flag);
	endproperty
	a_ten_rd: assert property (p_ten_rd) else $error("bad 10b read");

	c_rx7: cover property (fall9 && ack_q && state_q == ST_RX);
	c_ten_hold: cover property (ua_set ##[1:1000] addr_wr);
	c_tx: cover property (tx_load && state_q == ST_TX);
	c_withheld: cover property (fall9 && hit_q && !ack_q);
endmodule

// ===== testbench/isar_master_model.sv
// Behavioural two-wire bus master driving the far side of the slave
`timescale 1ns/1ps
module isar_master_model (
	input wire logic scl,
	input wire logic sda,
	output logic scl_m,
	output logic sda_m
);
	localparam realtime Q = 31.25;
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	// Bounded wait, since the slave may hold the clock low
	task automatic wait_hi();
		int n;
		n = 0;
		while (scl !== 1'b1 && n < 10000) begin
			#4;
			n++;
		end
	endtask
	task automatic start();
		sda_m = 1'b1;
		#Q;
		scl_m = 1'b1;
		wait_hi();
		#Q;
		sda_m = 1'b0;
		#Q;
		scl_m = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_m = 1'b0;
		#Q;
		scl_m = 1'b1;
		wait_hi();
		#Q;
		sda_m = 1'b1;
		#(2 * Q);
	endtask
	task automatic bit_out(input logic b);
		sda_m = b;
		#Q;
		scl_m = 1'b1;
		wait_hi();
		#(2 * Q);
		scl_m = 1'b0;
		#Q;
	endtask
	task automatic bit_in(output logic b);
		sda_m = 1'b1;
		#Q;
		scl_m = 1'b1;
		wait_hi();
		#Q;
		b = sda;
		#Q;
		scl_m = 0;
		#Q;
	endtask
	// Bytes go out most significant bit first
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(b);
		ack = ~b;
	endtask
	task automatic rd_byte(input logic nack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		bit_out(nack);
	endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking testbench for the two-wire slave address receiver
`timescale 1ns/1ps
module tb_top
	import isar_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic en = 1'b1;
	logic pin_in = 1'b1;
	logic [3:0] mode = MODE_S7;
	logic addr_wr = 1'b0;
	logic [7:0] addr_wdata = 8'h00;
	logic [7:0] addr_mask = 8'h00;
	logic buf_rd = 1'b0;
	logic ovf_clr = 1'b0;
	logic pif_clr = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic scl_m, sda_m, scl_o, scl_oe, sda_o, sda_oe, tx_act, ack;
	logic [7:0] rbuf, areg, shreg, rd;
	isar_flags_t flags;
	wire logic scl;
	wire logic sda;
	int num_errors = 0;
	int n_tests = 0;
	logic [3:0] off_modes [2] = '{MODE_MST, MODE_FWM};
	logic [3:0] ss_modes [2] = '{MODE_S7SS, MODE_S10SS};
	// Pull-ups on both lines; any party may pull low
	assign scl = scl_m & (scl_oe ? scl_o : 1'b1);
	assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
	always #2 clk = ~clk;
	isar_master_model mst_u (.scl(scl), .sda(sda), .scl_m(scl_m),
		.sda_m(sda_m));
	isar_slave dut_u (.clk(clk), .rstn(rstn), .port_enable_bit(en),
		.port_mode(mode), .pins_are_inputs(pin_in), .scl_i(scl),
		.sda_i(sda), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
		.sda_oe(sda_oe), .addr_wr(addr_wr), .addr_wdata(addr_wdata),
		.addr_mask(addr_mask), .buf_rd(buf_rd), .ovf_clr(ovf_clr),
		.pif_clr(pif_clr), .tx_data(tx_data), .receive_buffer(rbuf),
		.slave_address_reg(areg), .input_shift_register(shreg),
		.flags(flags), .tx_active(tx_act));
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic chkf(input logic [3:0] e);
		chk("flags", {4'h0, flags}, {4'h0, e});
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask
	task automatic set_addr(input logic [7:0] d);
		@(negedge clk);
		addr_wdata = d;
		pulse(addr_wr);
	endtask
	task automatic sendb(input logic [7:0] d, input logic e);
		mst_u.wr_byte(d, ack);
		chk("ack", {7'h00, ack}, {7'h00, e});
	endtask
	task automatic give_verdict();
		$display("Checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Whole run is under twenty microseconds
	initial begin
		#60000;
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		chkf(4'h0);
		chk("sda_oe", {7'h00, sda_oe}, 8'h00);
		set_addr(8'hA4);
		chk("addr", areg, 8'hA4);
		mst_u.start();
		sendb(8'h40, 1'b0);
		chkf(4'h0);
		mst_u.stop();
		mst_u.start();
		sendb(8'hA4, 1'b1);
		chk("rbuf", rbuf, 8'hA4);
		chkf(4'h3);
		chk("shreg", shreg, 8'hA4);
		sendb(8'h5A, 1'b0);
		chk("rbuf", rbuf, 8'hA4);
		chkf(4'h7);
		pulse(buf_rd);
		chkf(4'h5);
		pulse(ovf_clr);
		pulse(pif_clr);
		chkf(4'h0);
		sendb(8'h3C, 1'b1);
		chk("rbuf", rbuf, 8'h3C);
		mst_u.stop();
		chk("sda_oe", {7'h00, sda_oe}, 8'h00);
		pulse(buf_rd);
		pulse(pif_clr);
		addr_mask = 8'h06;
		mst_u.start();
		sendb(8'hA2, 1'b1);
		chk("rbuf", rbuf, 8'hA2);
		mst_u.stop();
		pulse(buf_rd);
		pulse(pif_clr);
		addr_mask = 8'h00;
		foreach (off_modes[i]) begin
			@(negedge clk);
			mode = off_modes[i];
			mst_u.start();
			sendb(8'hA4, 1'b0);
			mst_u.stop();
		end
		@(negedge clk);
		mode = MODE_S7;
		en = 1'b0;
		mst_u.start();
		sendb(8'hA4, 1'b0);
		mst_u.stop();
		@(negedge clk);
		en = 1'b1;
		pin_in = 1'b0;
		mst_u.start();
		sendb(8'hA4, 1'b0);
		mst_u.stop();
		chkf(4'h0);
		@(negedge clk);
		pin_in = 1'b1;
		foreach (ss_modes[i]) begin
			mode = ss_modes[i];
			mst_u.start();
			chkf(4'h1);
			pulse(pif_clr);
			mst_u.stop();
			chkf(4'h1);
			pulse(pif_clr);
		end
		mode = MODE_S10;
		set_addr(8'hF2);
		tx_data = 8'h96;
		mst_u.start();
		sendb(8'hF2, 1'b1);
		chkf(4'hB);
		#500;
		chk("scl_oe", {7'h00, scl_oe}, 8'h01);
		pulse(buf_rd);
		pulse(pif_clr);
		set_addr(8'h34);
		chkf(4'h0);
		chk("scl_oe", {7'h00, scl_oe}, 8'h00);
		sendb(8'h34, 1'b1);
		chkf(4'hB);
		pulse(buf_rd);
		pulse(pif_clr);
		set_addr(8'hF2);
		mst_u.start();
		sendb(8'hF3, 1'b1);
		chkf(4'h3);
		chk("tx_act", {7'h00, tx_act}, 8'h01);
		mst_u.rd_byte(1'b1, rd);
		chk("rd", rd, 8'h96);
		mst_u.stop();
		give_verdict();
	end
endmodule
